// ==== hdl/dcp_ctrl.sv ====
// Diskette command port, DMA transfer sequencing and abort detection
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module dcp_ctrl
  import dcp_pkg::*;
#(
  parameter logic [15:0] DATA_WORDS = DATA_LEN,
  parameter logic [15:0] HDR_WORDS  = HDR_LEN,
  parameter logic [15:0] WIN_CYCLES = WIN_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        poc_n,
  input  wire logic        fmt_sync,
  input  wire logic        mem_ready,
  input  wire logic        index_hole,
  input  wire logic        sector_hole,
  input  wire logic        hdr_checked,
  input  wire logic        xfer_due,
  output logic             dma_req,
  output logic             dma_write,
  output logic             dma_data,
  output logic             step_pulse,
  output logic             step_dir_edge,
  output logic             restore,
  output logic [3:0]       drive_sel,
  output logic             unit_left,
  output logic             load_left,
  output logic             load_right
);
  dcp_state_t s;
  dcp_state_t next_s;

  logic       setup;
  logic       wr;
  logic       mapped;
  logic       idx_rise;
  logic       sec_rise;
  logic       sec_first;
  logic [1:0] drive_num;

  assign setup     = psel && !penable;
  assign wr        = psel && penable && pwrite;
  assign mapped    = (paddr == CMD_OFS) || (paddr == XCTL_OFS) || (paddr == STAT_OFS);
  assign idx_rise  = index_hole && !s.idx_d;
  assign sec_rise  = sector_hole && !s.sec_d;
  assign sec_first = sec_rise && s.saw_index;

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = s.prdata;

  always_comb begin
    next_s = s;
    next_s.idx_d = index_hole;
    next_s.sec_d = sector_hole;
    if (s.step_cnt != 8'h00) begin
      next_s.step_cnt = s.step_cnt - 8'h01;
    end
    if (s.win != 16'h0000) begin
      next_s.win = s.win - 16'h0001;
    end
    // Checked header opens the data write window
    if (hdr_checked) begin
      next_s.win = WIN_CYCLES;
    end
    if (idx_rise) begin
      next_s.saw_index = 1'b1;
    end
    if (sec_rise) begin
      next_s.saw_index = 1'b0;
    end
    // Clear first so that a same-cycle set wins
    if (wr && paddr == STAT_OFS) begin
      next_s.flags = s.flags & ~pwdata[6:0];
    end
    if (wr && paddr == CMD_OFS) begin
      next_s.cmd = pwdata[7:0];
      if (!pwdata[CMD_STEP_N]) begin
        next_s.step_cnt = STEP_CYC;
      end
    end
    if (s.active) begin
      if (!poc_n) begin
        next_s.flags[FL_POC] = 1'b1;
        next_s.active = 1'b0;
      end else if (sec_first) begin
        next_s.flags[FL_SECTOR] = 1'b1;
        next_s.active = 1'b0;
      end else if (xfer_due) begin
        next_s.flags[FL_NOCOMP] = 1'b1;
        next_s.active = 1'b0;
      end else if (!mem_ready) begin
        next_s.flags[FL_MEMNR] = 1'b1;
        next_s.active = 1'b0;
      end else begin
        next_s.count = s.count - 16'h0001;
        if (s.count == 16'h0001) begin
          next_s.active = 1'b0;
          next_s.flags[FL_DONE] = 1'b1;
          // Written header lets its data block follow
          if (s.is_write && !s.is_data) begin
            next_s.win = WIN_CYCLES;
          end
        end
      end
    end else if (wr && paddr == XCTL_OFS && pwdata[XC_GO]) begin
      if (!fmt_sync) begin
        next_s.flags[FL_NOSYNC] = 1'b1;
      end else if (pwdata[XC_DATA] && pwdata[XC_WRITE] && s.win == 16'h0000) begin
        next_s.flags[FL_WMISS] = 1'b1;
      end else begin
        next_s.active   = 1'b1;
        next_s.is_data  = pwdata[XC_DATA];
        next_s.is_write = pwdata[XC_WRITE];
        next_s.count    = pwdata[XC_DATA] ? DATA_WORDS : HDR_WORDS;
        if (pwdata[XC_DATA]) begin
          next_s.win = 16'h0000;
        end
      end
    end
    if (setup) begin
      case (paddr)
        XCTL_OFS: next_s.prdata = {29'h0, s.is_write, s.is_data, s.active};
        STAT_OFS: next_s.prdata = {s.count, 7'h00, (s.win != 16'h0000), s.active, s.flags};
        default:  next_s.prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{cmd: CMD_RST, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign dma_req       = s.active;
  assign dma_write     = s.is_write;
  assign dma_data      = s.is_data;
  assign step_pulse    = (s.step_cnt != 8'h00);
  assign step_dir_edge = s.cmd[CMD_DIR];
  assign restore       = s.cmd[CMD_RESTORE];
  assign unit_left     = s.cmd[CMD_UNIT_L];
  assign load_left     = s.cmd[CMD_LOAD_L];
  assign load_right    = s.cmd[CMD_LOAD_R];
  assign drive_num     = {~s.cmd[CMD_DSEL0], ~s.cmd[CMD_DSEL1]};

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_dsel
      assign drive_sel[g] = (drive_num == 2'(g));
    end
  endgenerate

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence cmd_wr;
    wr && paddr == CMD_OFS;
  endsequence
  sequence go_wr;
    wr && paddr == XCTL_OFS && pwdata[XC_GO] && !s.active;
  endsequence

  dir_follows_a: assert property (cmd_wr |=> step_dir_edge == $past(pwdata[CMD_DIR]))
    else $error("direction output does not follow command write");
  restore_out_a: assert property (cmd_wr |=> restore == $past(pwdata[CMD_RESTORE]))
    else $error("restore output does not follow command write");
  data_needs_hdr_a: assert property (go_wr ##0 (pwdata[XC_DATA] && pwdata[XC_WRITE]
    && fmt_sync && s.win == 16'h0000) |=> s.flags[FL_WMISS] && !s.active)
    else $error("data write started without a header window");
  poc_abort_a: assert property (s.active && !poc_n |=> !s.active && s.flags[FL_POC])
    else $error("power-on clear did not abort transfer");
  nosync_abort_a: assert property (go_wr ##0 !fmt_sync |=> !s.active && s.flags[FL_NOSYNC])
    else $error("unsynchronised request was not aborted");
  mem_abort_a: assert property (s.active && poc_n && !sec_first && !xfer_due && !mem_ready
    |=> !s.active && s.flags[FL_MEMNR])
    else $error("memory not ready did not abort transfer");
  sector_abort_a: assert property (s.active && poc_n && sec_first
    |=> !s.active && s.flags[FL_SECTOR])
    else $error("first sector hole did not abort transfer");
  miss_window_a: assert property (hdr_checked |=> s.win == WIN_CYCLES)
    else $error("header check did not open write window");
  nocomp_flag_a: assert property (s.active && poc_n && !sec_first && xfer_due
    |=> !s.active && s.flags[FL_NOCOMP])
    else $error("incomplete count not flagged when due");
  data_len_a: assert property (go_wr ##0 (fmt_sync && pwdata[XC_DATA] && !pwdata[XC_WRITE])
    |=> s.active && s.count == DATA_WORDS)
    else $error("data block length not loaded");
  step_width_a: assert property ($rose(step_pulse) |-> step_pulse [*8])
    else $error("step pulse too short");
  step_load_a: assert property (cmd_wr ##0 !pwdata[CMD_STEP_N] |=> s.step_cnt == STEP_CYC)
    else $error("step pulse counter not loaded");
  count_step_a: assert property (s.active && poc_n && !sec_first && !xfer_due && mem_ready
    |=> s.count == $past(s.count) - 16'h0001)
    else $error("length counter did not count down");
  done_flag_a: assert property (s.active && poc_n && !sec_first && !xfer_due && mem_ready
    && s.count == 16'h0001 |=> !s.active && s.flags[FL_DONE])
    else $error("transfer did not complete at zero count");
  hdr_window_a: assert property (s.active && poc_n && !sec_first && !xfer_due && mem_ready
    && s.count == 16'h0001 && s.is_write && !s.is_data |=> s.win == WIN_CYCLES)
    else $error("written header did not open data window");
  data_close_a: assert property (go_wr ##0 (fmt_sync && pwdata[XC_DATA] && s.win != 16'h0000)
    |=> s.active && s.win == 16'h0000)
    else $error("data start did not consume window");
  drive_hot_a: assert property ($onehot(drive_sel) && (drive_sel[3] == (s.cmd[3:2] == 2'b00)))
    else $error("drive select decode wrong");
endmodule
`default_nettype wire

// ==== pkg/dcp_pkg.sv ====
// Constants and types for the diskette command port and transfer abort logic
package dcp_pkg;
  localparam logic [7:0]  CMD_OFS     = 8'h00;
  localparam logic [7:0]  XCTL_OFS    = 8'h04;
  localparam logic [7:0]  STAT_OFS    = 8'h08;
  localparam logic [7:0]  CMD_RST     = 8'h01;
  localparam int          CMD_STEP_N  = 0;
  localparam int          CMD_DIR     = 1;
  localparam int          CMD_DSEL0   = 2;
  localparam int          CMD_DSEL1   = 3;
  localparam int          CMD_RESTORE = 4;
  localparam int          CMD_LOAD_L  = 5;
  localparam int          CMD_LOAD_R  = 6;
  localparam int          CMD_UNIT_L  = 7;
  localparam int          XC_GO       = 0;
  localparam int          XC_DATA     = 1;
  localparam int          XC_WRITE    = 2;
  localparam int          FL_POC      = 0;
  localparam int          FL_NOSYNC   = 1;
  localparam int          FL_MEMNR    = 2;
  localparam int          FL_SECTOR   = 3;
  localparam int          FL_WMISS    = 4;
  localparam int          FL_NOCOMP   = 5;
  localparam int          FL_DONE     = 6;
  localparam int          CLK_NS      = 20;
  localparam int          STEP_NS     = 1000;
  localparam logic [7:0]  STEP_CYC    = 8'((STEP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] DATA_LEN    = 16'h1000;
  localparam logic [15:0] HDR_LEN     = 16'h0010;
  localparam logic [15:0] WIN_CYC     = 16'h07d0;

  typedef struct packed {
    logic [7:0]  cmd;
    logic [7:0]  step_cnt;
    logic        active;
    logic        is_data;
    logic        is_write;
    logic [15:0] count;
    logic [15:0] win;
    logic [6:0]  flags;
    logic        saw_index;
    logic        idx_d;
    logic        sec_d;
    logic [31:0] prdata;
  } dcp_state_t;
endpackage

// ==== tb/dcp_far.sv ====
// Formatter, hole sensors and host memory seen from the controller
`timescale 1ns/1ps
`default_nettype none
module dcp_far (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic sync_en,
  input  wire logic stall,
  input  wire logic holes,
  output logic      fmt_sync,
  output logic      mem_ready,
  output logic      index_hole,
  output logic      sector_hole
);
  logic [2:0] ph;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ph <= 3'h0;
    else if (holes) ph <= 3'h1;
    else if (ph != 3'h0) ph <= ph + 3'h1;
  end
  // Index hole passes first, sector hole two cycles later
  assign index_hole  = (ph == 3'h2);
  assign sector_hole = (ph == 3'h4) || (ph == 3'h5);
  assign fmt_sync    = sync_en;
  assign mem_ready   = !stall;
endmodule
`default_nettype wire

// ==== tb/test_dcp_ctrl.sv ====
// Bench for the diskette command port and transfer abort logic
`timescale 1ns/1ps
`default_nettype none
module test_dcp_ctrl;
  import dcp_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        poc_n, fmt_sync, mem_ready, index_hole, sector_hole, hdr_checked, xfer_due;
  logic        dma_req, dma_write, dma_data, step_pulse, step_dir_edge, restore;
  logic        unit_left, load_left, load_right, er, sync, stall, holes;
  logic [3:0]  drive_sel;
  int          n_mismatch, check_count, cyc;
  logic [3:0]  dt [4] = '{4'b1000, 4'b0010, 4'b0100, 4'b0001};
  dcp_ctrl #(.HDR_WORDS(16'h0004), .WIN_CYCLES(16'h0014)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .poc_n, .fmt_sync, .mem_ready, .index_hole, .sector_hole, .hdr_checked, .xfer_due,
    .dma_req, .dma_write, .dma_data, .step_pulse, .step_dir_edge, .restore, .drive_sel,
    .unit_left, .load_left, .load_right);
  dcp_far far (.pclk, .presetn, .sync_en(sync), .stall, .holes, .fmt_sync, .mem_ready,
    .index_hole, .sector_hole);
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      wrap_up;
    end
  end
  task cmp(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // Clear flags, start a transfer, inject at most one fault, then read status
  task run(input logic [2:0] x, input int c, input logic [31:0] m, input logic [31:0] e);
    apb(1'b1, STAT_OFS, 32'h0000_007f);
    if (c == 5) sync <= 1'b0;
    // Checked header pulse opens the data write window
    if (c == 6) begin
      hdr_checked <= 1'b1;
      @(posedge pclk);
      hdr_checked <= 1'b0;
    end
    apb(1'b1, XCTL_OFS, {29'h0, x});
    repeat (3) @(posedge pclk);
    if (e[6]) cmp({29'h0, dma_req, dma_write, dma_data}, {29'h0, 1'b1, x[2], x[1]});
    case (c)
      1: poc_n <= 1'b0;
      2: stall <= 1'b1;
      3: holes <= 1'b1;
      4: xfer_due <= 1'b1;
      default: ;
    endcase
    @(posedge pclk);
    holes <= 1'b0; xfer_due <= 1'b0;
    for (int k = 0; k < 9000 && dma_req === 1'b1; k++) @(posedge pclk);
    poc_n <= 1'b1; stall <= 1'b0; sync <= 1'b1;
    apb(1'b0, STAT_OFS, 32'h0);
    cmp(rd & m, e);
  endtask
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; poc_n = 1'b1; hdr_checked = 1'b0; xfer_due = 1'b0;
    sync = 1'b1; stall = 1'b0; holes = 1'b0;
    n_mismatch = 0; check_count = 0; cyc = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    cmp({27'h0, step_pulse, drive_sel}, 32'h0000_0008);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, CMD_OFS, {24'h0, i[1], ~i[0], i[0], i[0], i[1:0], i[1], 1'b1});
      @(negedge pclk);
      cmp({25'h0, step_dir_edge, restore, unit_left, load_left, load_right, 2'h0},
          {25'h0, i[1], i[0], i[1], i[0], ~i[0], 2'h0});
      cmp({28'h0, drive_sel}, {28'h0, dt[i]});
    end
    apb(1'b1, CMD_OFS, 32'h0000_0000);
    repeat (2) @(negedge pclk);
    cmp({31'h0, step_pulse}, 32'h1);
    repeat (50) @(negedge pclk);
    cmp({31'h0, step_pulse}, 32'h0);
    apb(1'b0, CMD_OFS, 32'h0);
    cmp(rd, 32'h0);
    apb(1'b0, 8'h0c, 32'h0);
    cmp({31'h0, er}, 32'h1);
    run(3'b101, 0, 32'hffff_ffff, 32'h0000_0140);
    run(3'b111, 0, 32'hffff_ffff, 32'h0000_0040);
    run(3'b111, 0, 32'h0000_00ff, 32'h0000_0010);
    run(3'b111, 6, 32'hffff_ffff, 32'h0000_0040);
    run(3'b011, 1, 32'h0000_00ff, 32'h0000_0001);
    run(3'b011, 5, 32'h0000_00ff, 32'h0000_0002);
    run(3'b011, 2, 32'h0000_00ff, 32'h0000_0004);
    run(3'b011, 3, 32'h0000_00ff, 32'h0000_0008);
    run(3'b011, 4, 32'h0000_00ff, 32'h0000_0020);
    wrap_up;
  end
endmodule
`default_nettype wire
